// >>> include/ictx_pkg.sv
// constants and types for the iec958 transmitter with subcode output
// ----------------------------------------------------------------
// What this block does
// [R1] only 20 audio bits per sample; four lowest slot bits always zero
// [R2] two serial outputs, consumer and professional status layouts only differ
// [R3] after reset both outputs toggle at crystal clock over sixteen until enabled
// [R4] consumer status bits 0-31 from register, bit 31 first, rest zero
// [R5] professional bits 0-23 from 31:8, 24-183 zero, 184-191 from 7:0
// [R6] software loads professional low byte with crc of status frame
// [R7] transmit sample buffer flags underrun, overrun and empty
// [R8] transmit clock kept at or below one third of system clock
// [R9] frames carry status, user bits and software controlled validity flag
// [R10] user channel carries only cd subcode symbols
// [R11] one subcode word source feeds both user channel and subcode port
// [R12] software writes next four subcode bytes into user word register
// [R13] flag raised when user word consumed and needs reload
// [R14] flag raised when user word needed but not reloaded
// [R15] flag raised when next word must hold first byte of packet
// [R16] preset count loads position counter only with preset enable set
// [R17] sync low first bit of each symbol, first two of packet start
// [R18] internal timing inserts one symbol every twelve user bits
// [R19] subcode data sent msb first on external bit clock
// [R20] two sync slots sent as zero, software fills other 96 slots
// ----------------------------------------------------------------
package ictx_pkg;
   // register map
   localparam logic [7:0] OFS_CONS = 8'h28;
   localparam logic [7:0] OFS_PRO = 8'h2C;
   localparam logic [7:0] OFS_CTRL = 8'h30;
   localparam logic [7:0] OFS_UWORD = 8'h84;
   localparam logic [7:0] OFS_SUB = 8'h92;
   localparam logic [7:0] OFS_STAT = 8'h94;
   // fields
   localparam int CTL_RUN = 0;
   localparam int CTL_VALID = 1;
   localparam int SUB_INT_TIM = 0;
   localparam int SUB_PRESET_EN = 15;
   localparam int SUB_PRESET_LSB = 8;
   localparam int ST_POS_LSB = 8;
   localparam int ST_FLAGS = 6;
   // idle clock divide
   localparam int IDLE_DIV = 16;
   localparam int IDLE_DIV_LOG2 = 4;
   // frame layout
   localparam logic [4:0] SLOT_AUX = 5'h04;
   localparam logic [4:0] SLOT_AUD0 = 5'h08;
   localparam logic [4:0] SLOT_AUD1 = 5'h1B;
   localparam logic [4:0] SLOT_V = 5'h1C;
   localparam logic [4:0] SLOT_U = 5'h1D;
   localparam logic [4:0] SLOT_C = 5'h1E;
   localparam logic [4:0] SLOT_P = 5'h1F;
   localparam logic [7:0] FRAME_LAST = 8'hBF;
   localparam logic [7:0] CONS_BITS = 8'h20;
   localparam logic [7:0] PRO_HEAD = 8'h18;
   localparam logic [7:0] PRO_CRC = 8'hB8;
   localparam logic [7:0] PRE_B = 8'hE8;
   localparam logic [7:0] PRE_M = 8'hE2;
   localparam logic [7:0] PRE_W = 8'hE4;
   localparam int ZERO_LSB = 4;
   // subcode packet
   localparam logic [6:0] PKT_SYNC = 7'h02;
   localparam logic [6:0] PKT_LAST = 7'h61;
   localparam logic [3:0] SYM_LAST = 4'hB;
   localparam logic [7:0] SYM_MARK = 8'h80;
   typedef enum logic [0:0] {LINE_IDLE = 1'b0, LINE_RUN = 1'b1} ictx_line_t;
endpackage

// >>> include/ictx_sym_if.sv
// symbol hand-off between transmitter core and subcode port
`timescale 1ns/100ps
`default_nettype none
interface ictx_sym_if;
   logic [7:0] sym_byte;
   logic sym_first;
   logic sym_restart;
   logic take;
   modport main(output sym_byte, output sym_first, output sym_restart, input take);
   modport port(input sym_byte, input sym_first, input sym_restart, output take);
endinterface
`default_nettype wire

// >>> core/ictx_subcode_port.sv
// three-wire subcode serializer on the external bit clock
`timescale 1ns/100ps
`default_nettype none
module ictx_subcode_port (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic subcode_bit_clk,
   output logic subcode_sync_out,
   output logic subcode_data_out,
   ictx_sym_if.port sym
);
   typedef struct packed {
      logic [2:0] sync;
      logic [2:0] bitn;
      logic [7:0] shift;
      logic first;
      logic sfsy;
      logic subr;
   } ictx_port_t;
   ictx_port_t st;
   ictx_port_t nx;
   logic edge_seen;

   // ----------------------------------------------------------------
   // serializer
   // ----------------------------------------------------------------
   assign edge_seen = st.sync[1] & ~st.sync[2];
   assign sym.take = edge_seen && st.bitn == 3'h0 && !sym.sym_restart;

   always_comb begin
      nx = st;
      nx.sync = {st.sync[1:0], subcode_bit_clk};
      if (sym.sym_restart) begin
         nx.bitn = 3'h0;
      end else if (edge_seen) begin
         nx.bitn = st.bitn + 3'h1;
         if (st.bitn == 3'h0) begin
            nx.subr = sym.sym_byte[7]; // R19
            nx.shift = {sym.sym_byte[6:0], 1'b0};
            nx.first = sym.sym_first;
         end else begin
            nx.subr = st.shift[7]; // R19
            nx.shift = {st.shift[6:0], 1'b0};
         end
         nx.sfsy = !(st.bitn == 3'h0 || (st.bitn == 3'h1 && st.first)); // R17
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.sfsy <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign subcode_sync_out = st.sfsy;
   assign subcode_data_out = st.subr;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sync_low_a: assert property ((edge_seen && !sym.sym_restart && st.bitn == 3'h1) // R17
      |=> subcode_sync_out == !$past(st.first)) else $error("sync flag wrong on second symbol bit");
   sync_high_a: assert property ((edge_seen && !sym.sym_restart && st.bitn > 3'h1) |=> subcode_sync_out) // R17
      else $error("sync flag low inside symbol");
   msb_first_a: assert property (sym.take |=> (subcode_data_out == $past(sym.sym_byte[7]) && !subcode_sync_out)) // R19
      else $error("symbol msb not sent first");
endmodule
`default_nettype wire

// >>> core/ictx_transmit.sv
// iec958 transmitter core with user channel subcode and register port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ictx_transmit #(
   parameter int IDLE_DIV_LOG2 = ictx_pkg::IDLE_DIV_LOG2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic [23:0] sample_data,
   input wire logic sample_valid,
   input wire logic tx_bit_clk,
   input wire logic subcode_bit_clk,
   output logic consumer_audio_out,
   output logic professional_audio_out,
   output logic subcode_sync_out,
   output logic subcode_data_out
);
   if (2 ** IDLE_DIV_LOG2 != ictx_pkg::IDLE_DIV) begin : g_bad_div
      $error("idle divider must give crystal over sixteen");
   end

   typedef struct packed {
      ictx_pkg::ictx_line_t mode;
      logic [IDLE_DIV_LOG2-1:0] div_cnt;
      logic [2:0] txc;
      logic [31:0] cons;
      logic [31:0] pro;
      logic [1:0] ctrl;
      logic [14:0] subctl;
      logic [31:0] uword;
      logic ufull;
      logic [1:0] uidx;
      logic [6:0] pos;
      logic [3:0] ucnt;
      logic [7:0] usym;
      logic [7:0] upend;
      logic upend_v;
      logic [ictx_pkg::ST_FLAGS-1:0] flags;
      logic [23:0] hold;
      logic hold_full;
      logic [19:0] shift;
      logic [4:0] slot;
      logic half;
      logic right;
      logic [7:0] frame;
      logic [1:0] lvl;
      logic [1:0] par;
      logic [1:0] base;
      logic [1:0] out;
      logic [31:0] rdata;
   } ictx_state_t;

   // flag positions in the status word
   localparam int F_UNDER = 0;
   localparam int F_OVER = 1;
   localparam int F_EMPTY = 2;
   localparam int F_UEMPTY = 3;
   localparam int F_UUNDER = 4;
   localparam int F_UPKT = 5;

   ictx_state_t st;
   ictx_state_t nx;
   ictx_sym_if sym();
   logic tick;
   logic run_tick;
   logic int_tim;
   logic u_load;
   logic consume;
   logic data_pos;
   logic drain;
   logic [31:0] word_shift;
   logic [7:0] cur_byte;
   logic [7:0] cur_u;
   logic wr_sub;

   function automatic logic ictx_cbit(input logic pro_sel, input logic [7:0] frame,
                                      input logic [31:0] cons, input logic [31:0] pro);
      logic [7:0] k;
      k = frame - ictx_pkg::PRO_CRC;
      ictx_cbit = 1'b0;
      if (!pro_sel) begin
         if (frame < ictx_pkg::CONS_BITS) begin
            ictx_cbit = cons[~frame[4:0]]; // R4
         end
      end else if (frame < ictx_pkg::PRO_HEAD) begin
         ictx_cbit = pro[~frame[4:0]]; // R5
      end else if (frame >= ictx_pkg::PRO_CRC) begin
         ictx_cbit = pro[~k[2:0]]; // R5
      end
   endfunction

   // ----------------------------------------------------------------
   // subcode symbol source, shared by user channel and port
   // ----------------------------------------------------------------
   assign tick = st.txc[1] & ~st.txc[2];
   assign run_tick = st.mode == ictx_pkg::LINE_RUN && st.ctrl[ictx_pkg::CTL_RUN] && tick;
   assign int_tim = st.subctl[ictx_pkg::SUB_INT_TIM];
   assign u_load = run_tick && st.half && st.slot == ictx_pkg::SLOT_U && st.ucnt == ictx_pkg::SYM_LAST;
   assign consume = int_tim ? u_load : sym.take; // R18
   assign data_pos = st.pos >= ictx_pkg::PKT_SYNC;
   assign word_shift = st.uword >> {~st.uidx, 3'b000};
   assign cur_byte = (data_pos && st.ufull) ? word_shift[7:0] : 8'h00; // R20
   assign cur_u = data_pos ? (cur_byte | ictx_pkg::SYM_MARK) : 8'h00; // R10
   assign drain = run_tick && !st.half && st.slot == ictx_pkg::SLOT_AUX;
   assign wr_sub = reg_write && reg_addr == ictx_pkg::OFS_SUB;
   assign sym.sym_byte = cur_byte; // R11
   assign sym.sym_first = st.pos == 7'h00;
   assign sym.sym_restart = wr_sub && reg_wdata[ictx_pkg::SUB_PRESET_EN];

   ictx_subcode_port u_port (
      .ref_clk(ref_clk),
      .rst(rst),
      .subcode_bit_clk(subcode_bit_clk),
      .subcode_sync_out(subcode_sync_out),
      .subcode_data_out(subcode_data_out),
      .sym(sym)
   );

   always_comb begin
      logic b;
      logic bse;
      logic [7:0] pre;
      logic [7:0] psh;
      logic [ictx_pkg::ST_FLAGS-1:0] set;
      logic [ictx_pkg::ST_FLAGS-1:0] clr;
      b = 1'b0;
      bse = 1'b0;
      pre = 8'h00;
      psh = 8'h00;
      set = '0;
      clr = '0;
      nx = st;
      nx.txc = {st.txc[1:0], tx_bit_clk};
      nx.div_cnt = st.div_cnt + 1'b1;
      nx.rdata = 32'h0000_0000;

      // ----------------------------------------------------------------
      // register writes
      // ----------------------------------------------------------------
      if (reg_write) begin
         case (reg_addr)
            ictx_pkg::OFS_CONS: nx.cons = reg_wdata;
            ictx_pkg::OFS_PRO: nx.pro = reg_wdata;
            ictx_pkg::OFS_CTRL: nx.ctrl = reg_wdata[1:0];
            ictx_pkg::OFS_STAT: clr = reg_wdata[ictx_pkg::ST_FLAGS-1:0];
            ictx_pkg::OFS_SUB: nx.subctl = reg_wdata[14:0];
            default: nx.ctrl = st.ctrl;
         endcase
      end

      // ----------------------------------------------------------------
      // line coder
      // ----------------------------------------------------------------
      case (st.mode)
         ictx_pkg::LINE_IDLE: begin
            // next count, so the first low phase after reset is not one cycle longer
            nx.lvl = {2{nx.div_cnt[IDLE_DIV_LOG2-1]}}; // R3
            nx.slot = 5'h00;
            nx.half = 1'b0;
            nx.right = 1'b0;
            nx.frame = 8'h00;
            nx.ucnt = 4'h0;
            nx.usym = 8'h00;
            if (st.ctrl[ictx_pkg::CTL_RUN]) begin
               nx.mode = ictx_pkg::LINE_RUN;
            end
         end
         ictx_pkg::LINE_RUN: begin
            if (!st.ctrl[ictx_pkg::CTL_RUN]) begin
               nx.mode = ictx_pkg::LINE_IDLE;
            end else if (tick) begin
               pre = st.right ? ictx_pkg::PRE_W : (st.frame == 8'h00 ? ictx_pkg::PRE_B : ictx_pkg::PRE_M);
               psh = pre << {st.slot[1:0], st.half};
               for (int i = 0; i < 2; i++) begin
                  // R9
                  if (st.slot >= ictx_pkg::SLOT_AUD0 && st.slot <= ictx_pkg::SLOT_AUD1) b = st.shift[0];
                  else if (st.slot == ictx_pkg::SLOT_V) b = st.ctrl[ictx_pkg::CTL_VALID];
                  else if (st.slot == ictx_pkg::SLOT_U) b = st.usym[7];
                  else if (st.slot == ictx_pkg::SLOT_C) b = ictx_cbit(i == 1, st.frame, st.cons, st.pro); // R2
                  else if (st.slot == ictx_pkg::SLOT_P) b = st.par[i];
                  else b = 1'b0; // R1
                  if (st.slot < ictx_pkg::SLOT_AUX) begin
                     bse = (st.slot == 5'h00 && !st.half) ? st.lvl[i] : st.base[i];
                     nx.base[i] = bse;
                     nx.lvl[i] = psh[7] ^ bse;
                     nx.par[i] = 1'b0;
                  end else if (!st.half || b) begin
                     nx.lvl[i] = ~st.lvl[i];
                  end
                  if (st.half && st.slot >= ictx_pkg::SLOT_AUX && st.slot != ictx_pkg::SLOT_P) begin
                     nx.par[i] = st.par[i] ^ b;
                  end
               end
               if (st.half && st.slot >= ictx_pkg::SLOT_AUD0 && st.slot <= ictx_pkg::SLOT_AUD1) begin
                  nx.shift = st.shift >> 1;
               end
               if (drain) begin
                  // only the upper 20 bits travel, the low nibble of the slot is the zeroed aux
                  nx.shift = st.hold_full ? st.hold[23:ictx_pkg::ZERO_LSB] : 20'h0_0000; // R1
                  nx.hold_full = 1'b0;
                  set[F_UNDER] = !st.hold_full; // R7
               end
               if (st.half && st.slot == ictx_pkg::SLOT_U) begin
                  if (u_load || st.ucnt == ictx_pkg::SYM_LAST) begin
                     nx.ucnt = 4'h0; // R18
                     nx.usym = int_tim ? cur_u : (st.upend_v ? st.upend : 8'h00); // R11
                     nx.upend_v = 1'b0;
                  end else begin
                     nx.ucnt = st.ucnt + 4'h1;
                     nx.usym = {st.usym[6:0], 1'b0};
                  end
               end
               if (st.half) begin
                  nx.slot = st.slot + 5'h01;
                  if (st.slot == ictx_pkg::SLOT_P) begin
                     nx.right = ~st.right;
                     if (st.right) nx.frame = (st.frame == ictx_pkg::FRAME_LAST) ? 8'h00 : st.frame + 8'h01;
                  end
               end
               nx.half = ~st.half;
            end
         end
         default: nx.mode = ictx_pkg::LINE_IDLE;
      endcase
      nx.out = nx.lvl;

      // ----------------------------------------------------------------
      // symbol consumption and user word
      // ----------------------------------------------------------------
      if (consume) begin
         if (data_pos) begin
            if (st.ufull) begin
               nx.uidx = st.uidx + 2'h1;
               if (st.uidx == 2'h3) begin
                  nx.ufull = 1'b0;
                  set[F_UEMPTY] = 1'b1; // R13
                  set[F_UPKT] = st.pos == ictx_pkg::PKT_LAST; // R15
               end
            end else begin
               set[F_UUNDER] = 1'b1; // R14
            end
         end
         nx.pos = (st.pos == ictx_pkg::PKT_LAST) ? 7'h00 : st.pos + 7'h01;
         if (!int_tim) begin
            nx.upend = cur_u; // R11
            nx.upend_v = 1'b1;
         end
      end
      if (reg_write && reg_addr == ictx_pkg::OFS_UWORD) begin
         nx.uword = reg_wdata; // R12
         nx.ufull = 1'b1;
         nx.uidx = 2'h0;
      end
      if (sym.sym_restart) begin
         // presets beyond the packet end are clamped to its last slot
         nx.pos = (reg_wdata[14:8] > ictx_pkg::PKT_LAST) ? ictx_pkg::PKT_LAST : reg_wdata[14:8]; // R16
      end

      // ----------------------------------------------------------------
      // sample holding register and flags
      // ----------------------------------------------------------------
      if (sample_valid) begin
         set[F_OVER] = st.hold_full && !drain; // R7
         nx.hold = sample_data;
         nx.hold_full = 1'b1;
      end
      // a set in the clearing cycle wins
      nx.flags = (st.flags & ~clr) | set;
      nx.flags[F_EMPTY] = ~nx.hold_full; // R7

      if (reg_read) begin
         case (reg_addr)
            ictx_pkg::OFS_CONS: nx.rdata = st.cons;
            ictx_pkg::OFS_PRO: nx.rdata = st.pro;
            ictx_pkg::OFS_CTRL: nx.rdata = {30'h0000_0000, st.ctrl};
            ictx_pkg::OFS_UWORD: nx.rdata = st.uword;
            ictx_pkg::OFS_SUB: nx.rdata = {17'h0_0000, st.subctl};
            ictx_pkg::OFS_STAT: nx.rdata = {17'h0_0000, st.pos, 2'b00, st.flags};
            default: nx.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.flags[F_UEMPTY] <= 1'b1;
         st.flags[F_EMPTY] <= 1'b1;
      end else begin
         st <= nx;
      end
   end

   assign reg_rdata = st.rdata;
   assign consumer_audio_out = st.out[0];
   assign professional_audio_out = st.out[1];

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   aux_zero_a: assert property ((run_tick && st.half && st.slot >= ictx_pkg::SLOT_AUX && st.slot < ictx_pkg::SLOT_AUD0) // R1
      |=> st.out == $past(st.out)) else $error("aux slot not sent as zero");
   outputs_differ_a: assert property ((run_tick && !(st.half && st.slot >= ictx_pkg::SLOT_C)) // R2
      |=> (st.out[0] ^ st.out[1]) == $past(st.out[0] ^ st.out[1])) else $error("outputs differ outside status");
   idle_clock_a: assert property (st.mode == ictx_pkg::LINE_IDLE ##1 (st.mode == ictx_pkg::LINE_IDLE)[*8] // R3
      ##1 st.mode == ictx_pkg::LINE_IDLE |-> (st.out[0] != $past(st.out[0], 8)) && (st.out[0] == st.out[1]))
      else $error("idle clock wrong");
   cons_tail_a: assert property ((run_tick && st.half && st.slot == ictx_pkg::SLOT_C && st.frame >= ictx_pkg::CONS_BITS) // R4
      |=> $stable(st.out[0])) else $error("consumer status tail not zero");
   pro_middle_a: assert property ((run_tick && st.half && st.slot == ictx_pkg::SLOT_C // R5
      && st.frame >= ictx_pkg::PRO_HEAD && st.frame < ictx_pkg::PRO_CRC) |=> $stable(st.out[1]))
      else $error("professional status middle not zero");
   fifo_under_a: assert property ((drain && !st.hold_full) |=> st.flags[F_UNDER]) // R7
      else $error("sample underrun not flagged");
   u_empty_a: assert property ((consume && data_pos && st.ufull && st.uidx == 2'h3) // R13
      |=> st.flags[F_UEMPTY] && !(st.ufull && st.uidx == 2'h0 && !$past(reg_write))) else $error("user word empty not flagged");
   u_under_a: assert property ((consume && data_pos && !st.ufull) |=> st.flags[F_UUNDER]) // R14
      else $error("user word underrun not flagged");
   pkt_start_a: assert property ((consume && !sym.sym_restart && st.pos == ictx_pkg::PKT_LAST // R15
      && st.ufull && st.uidx == 2'h3) |=> st.flags[F_UPKT] && st.flags[F_UEMPTY] && st.pos == 7'h00)
      else $error("packet start not flagged");
   preset_hold_a: assert property ((wr_sub && !reg_wdata[ictx_pkg::SUB_PRESET_EN] && !consume) // R16
      |=> st.pos == $past(st.pos)) else $error("position moved without preset enable");
   preset_load_a: assert property ((sym.sym_restart && reg_wdata[14:8] <= ictx_pkg::PKT_LAST) // R16
      |=> st.pos == $past(reg_wdata[14:8])) else $error("preset not loaded");
   sym_period_a: assert property ((u_load && int_tim && !sym.sym_restart) |=> st.ucnt == 4'h0 && st.usym == $past(cur_u) // R18
      ##1 (st.ucnt == 4'h0)[*2]) else $error("internal symbol not loaded");
endmodule
`default_nettype wire

// >>> sim/ictx_partner.sv
// far-side model: transmit clock source and subcode channel encoder
`timescale 1ns/100ps
`default_nettype none
module ictx_partner (
   output logic tx_bit_clk,
   output logic subcode_bit_clk,
   input wire logic subcode_sync_out,
   input wire logic subcode_data_out
);
   // ----------------------------------------
   // clocks
   // ----------------------------------------
   // 25 mhz, kept under a third of the system rate
   initial begin
      tx_bit_clk = 1'b0;
      forever #20 tx_bit_clk = ~tx_bit_clk;
   end
   // bit clock stands still outside symbol reads
   initial subcode_bit_clk = 1'b0;
   // halves of 8 system cycles so the synced outputs have settled when sampled
   task automatic take_sym(output logic [7:0] dat, output logic [7:0] syn);
      for (int i = 7; i >= 0; i--) begin
         subcode_bit_clk = 1'b1;
         #40;
         dat[i] = subcode_data_out;
         syn[i] = subcode_sync_out;
         subcode_bit_clk = 1'b0;
         #40;
      end
   endtask
endmodule
`default_nettype wire

// >>> sim/iec958_transmit_subcode_out_tb.sv
// self-checking bench for the iec958 transmitter with subcode port
`timescale 1ns/100ps
`default_nettype none
module iec958_transmit_subcode_out_tb;
   logic ref_clk, rst, reg_write, reg_read, sample_valid;
   logic [7:0] reg_addr, d, s;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [23:0] sample_data;
   logic tx_bit_clk, subcode_bit_clk, cons_out, pro_out, sync_out, data_out;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   localparam logic [31:0] WORD = 32'hA5C3_0F81;
   localparam logic [23:0] PRO_HDR = 24'h12_3456;
   // crc seed is not fixed for this block, plain default
   localparam logic [7:0] CRC_INIT = 8'h00;
   ictx_transmit DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_data(sample_data),
      .sample_valid(sample_valid), .tx_bit_clk(tx_bit_clk), .subcode_bit_clk(subcode_bit_clk),
      .consumer_audio_out(cons_out), .professional_audio_out(pro_out),
      .subcode_sync_out(sync_out), .subcode_data_out(data_out));
   ictx_partner enc (.tx_bit_clk(tx_bit_clk), .subcode_bit_clk(subcode_bit_clk),
      .subcode_sync_out(sync_out), .subcode_data_out(data_out));
   // ----------------------------------------
   // bus and report tasks
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] dt);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= dt;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1 r = reg_rdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // status frame crc as software loads it: header bits first, then 160 zero bits
   function automatic logic [7:0] crc8(input logic [23:0] hdr);
      logic [7:0] c;
      c = CRC_INIT;
      for (int k = 23; k >= 0; k--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ hdr[k]) ? 8'h1D : 8'h00);
      end
      for (int k = 0; k < 160; k++) begin
         c = {c[6:0], 1'b0} ^ (c[7] ? 8'h1D : 8'h00);
      end
      return c;
   endfunction
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_idle();
      @(posedge ref_clk);
      #1 v = {30'h0, pro_out, cons_out};
      chk({31'h0, v[1]}, {31'h0, v[0]});
      repeat (8) @(posedge ref_clk);
      #1 chk({30'h0, pro_out, cons_out}, {30'h0, ~v[1], ~v[0]});
   endtask
   task automatic t_regs();
      rd(8'h94, v);
      chk(v, 32'h0000_000C);
      rd(8'h92, v);
      chk(v, 32'h0000_0000);
      rd(8'h00, v);
      chk(v, 32'h0000_0000);
      wr(8'h28, WORD);
      rd(8'h28, v);
      chk(v, WORD);
      wr(8'h2C, {PRO_HDR, crc8(PRO_HDR)});
      rd(8'h2C, v);
      chk(v, {PRO_HDR, crc8(PRO_HDR)});
   endtask
   // preset only moves the packet position when its enable is written too
   task automatic t_preset();
      wr(8'h92, 32'h0000_8300);
      rd(8'h94, v);
      chk(v & 32'h7F00, 32'h0000_0300);
      wr(8'h92, 32'h0000_0500);
      rd(8'h94, v);
      chk(v & 32'h7F00, 32'h0000_0300);
      rd(8'h92, v);
      chk(v, 32'h0000_0500);
   endtask
   // two sync symbols, four data bytes, then one slot with no reload
   task automatic t_sub();
      wr(8'h92, 32'h0000_8000);
      wr(8'h84, WORD);
      wr(8'h94, 32'h0000_0008);
      rd(8'h94, v);
      chk(v & 32'h8, 32'h0);
      enc.take_sym(d, s);
      chk({24'h0, s}, 32'h3F);
      chk({24'h0, d}, 32'h0);
      enc.take_sym(d, s);
      chk({24'h0, s}, 32'h7F);
      chk({24'h0, d}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         enc.take_sym(d, s);
         chk({24'h0, d}, (WORD >> (24 - 8 * i)) & 32'hFF);
         chk({24'h0, s}, 32'h7F);
      end
      rd(8'h94, v);
      chk(v & 32'h8, 32'h8);
      enc.take_sym(d, s);
      repeat (4) @(posedge ref_clk);
      rd(8'h94, v);
      chk(v & 32'h10, 32'h10);
      wr(8'h94, 32'h0000_003F);
      wr(8'h92, 32'h0000_DE00);
      wr(8'h84, WORD);
      for (int i = 0; i < 4; i++) begin
         enc.take_sym(d, s);
      end
      rd(8'h94, v);
      chk(v & 32'h7F38, 32'h0000_0028);
   endtask
   // frames streaming, internal symbol timing, sample buffer flags
   task automatic t_run();
      wr(8'h94, 32'h0000_003F);
      wr(8'h92, 32'h0000_8701);
      wr(8'h30, 32'h0000_0003);
      rd(8'h30, v);
      chk(v, 32'h0000_0003);
      @(posedge ref_clk);
      sample_valid <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sample_valid <= 1'b0;
      rd(8'h94, v);
      chk(v & 32'h7, 32'h2);
      repeat (1200) @(posedge ref_clk);
      rd(8'h94, v);
      chk(v & 32'h17, 32'h7);
      repeat (4600) @(posedge ref_clk);
      rd(8'h94, v);
      chk(v & 32'h10, 32'h0);
      repeat (600) @(posedge ref_clk);
      rd(8'h94, v);
      chk(v & 32'h10, 32'h10);
   endtask
   // ----------------------------------------
   // clock, reset, sequence and timeout
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   initial begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      sample_data = 24'h00_0000;
      sample_valid = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_idle();
      t_regs();
      t_preset();
      t_sub();
      t_run();
      results();
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end
endmodule
`default_nettype wire
